// file: rtl/acmc_map.vh
// Purpose: constants for the conversion mode control block
// Assumes: included by every acmc design file
// Notes: register offsets are byte addresses on the register bus
`ifndef ACMC_MAP_VH
`define ACMC_MAP_VH

// conversion clock: oscillator divided by 32 * 64
`define ACMC_DIV_A 32
`define ACMC_DIV_B 64
`define ACMC_CONV_DIV (`ACMC_DIV_A * `ACMC_DIV_B)
// oversampling ratio at the fastest rate code
`define ACMC_OSR_MIN 2
`define ACMC_RATE_MAX 3'h7

// serial link counts
`define ACMC_DATA_BITS 24
`define ACMC_CNT_R10 6'h19
`define ACMC_CNT_SUP 6'h1A
`define ACMC_CNT_R40 6'h1B
`define ACMC_CNT_USER 6'h1C
`define ACMC_CNT_MAX 6'h20
`define ACMC_CNT_SAT 6'h3F

// conversion modes
`define ACMC_MODE_R10 2'h0
`define ACMC_MODE_SUP 2'h1
`define ACMC_MODE_R40 2'h2
`define ACMC_MODE_USER 2'h3

// fixed mode settings
`define ACMC_RATE_10 3'h0
`define ACMC_RATE_40 3'h2
`define ACMC_GAIN_1 3'h0
`define ACMC_GAIN_128 3'h7

// register offsets
`define ACMC_OFS_CTRL 4'h0
`define ACMC_OFS_STAT 4'h4
`define ACMC_OFS_RES 4'h8

// control register fields
`define ACMC_CTRL_RATE 2:0
`define ACMC_CTRL_GAIN 6:4
`define ACMC_CTRL_BUF 8
`define ACMC_CTRL_PSEL 9
`define ACMC_CTRL_NSEL 10
`define ACMC_CTRL_CHSEL 11
`define ACMC_CTRL_HALVE 12
`define ACMC_CTRL_REFSUP 13
`define ACMC_CTRL_RESET 14'h0270

// response codes
`define ACMC_RESP_OKAY 2'h0
`define ACMC_RESP_SLVERR 2'h2

`endif

// file: rtl/acmc_rate_div.v
// Purpose: conversion clock divider and output rate timer
// Assumes: clk is the internal oscillator clock
// Notes: conv_done pulses once per conversion period
`timescale 1ns/1ps
`default_nettype none
`include "acmc_map.vh"

module acmc_rate_div #(
    parameter CONV_DIV = `ACMC_CONV_DIV,
    parameter OSR_MIN = `ACMC_OSR_MIN
) (
    input wire clk,
    input wire resetn,
    input wire [2:0] rate_code,
    output reg conv_done
);

    reg [11:0] pre_q;
    reg [9:0] osr_q;
    wire conv_tick;
    wire [9:0] osr_len;

    // oversampling ratio doubles for each step down in rate code
    function [9:0] osr_of;
        input [2:0] code;
        begin
            osr_of = OSR_MIN[9:0] << (`ACMC_RATE_MAX - code);
        end
    endfunction

    assign osr_len = osr_of(rate_code);
    assign conv_tick = (pre_q == CONV_DIV[11:0] - 12'h001);

    // conversion clock enable, oscillator over 32 * 64
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 12'h000;
        end else if (conv_tick) begin
            pre_q <= 12'h000;
        end else begin
            pre_q <= pre_q + 12'h001;
        end
    end

    // count conversion clocks up to the ratio; a shortened ratio wraps at the next conversion clock
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osr_q <= 10'h000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_tick) begin
                if (osr_q + 10'h001 >= osr_len) begin
                    osr_q <= 10'h000;
                    conv_done <= 1'b1;
                end else begin
                    osr_q <= osr_q + 10'h001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/acmc_top.v
// Purpose: conversion mode control of a delta-sigma converter
// Assumes: clk is the internal oscillator clock; link pins synchronous to it
// Notes: register command mode on the link is not handled here
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acmc_map.vh"

// Function
// - conversion clock is the oscillator divided by 32 times 64
// - output rate is oscillator over 2048 times ratio, ratio 2 to 256
// - in user mode the conversion rate comes from the software written rate field
// - input buffer switched in only while its enable bit is set
// - in user mode amplifier gain 1 to 128 follows the written gain field
// - reference comes from the reference pin or the analog supply
// - fixed gain-128 modes route the two analog pins as the input
// - positive and negative selects let software swap the two pins
// - supply-difference mode routes divided supply and ground instead
// - supply-difference mode forces reference to the analog supply
// - user mode takes mux settings from registers, channel bit included
// - reference halved by default, setting a register bit turns halving off
// - result is 24-bit two's complement, zero input gives zero
// - full-scale inputs give largest positive and most negative codes
// - each result shifts out most significant bit first, one per pulse
// - at most 32 pulses per period are interpreted as a count
// - counts 25, 26, 27 select the three fixed modes
// - counts 28 through 32 select the user configured mode
// - a count under 25 carries into an extended second period
// - rate field code 0 is 10 per second up to 1280, default 0
// - gain field is two to the code, default code 7
// - input select 0 picks pin a, 1 pin b; positive defaults to 1
// - channel select 0 routes pins, 1 the internal supply channel
module acmc_top #(
    parameter CONV_DIV = `ACMC_CONV_DIV,
    parameter OSR_MIN = `ACMC_OSR_MIN
) (
    input wire clk,
    input wire resetn,
    // register bus
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [3:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // link pins
    input wire powerdown_shift_clock,
    output reg data_out,
    output wire data_out_oe,
    // digital filter result
    input wire [23:0] filter_result,
    // analog steering
    output reg [2:0] conv_rate_code,
    output reg [2:0] amp_gain_code,
    output reg input_buffer_on,
    output reg pos_pin_b,
    output reg neg_pin_b,
    output reg internal_channel_on,
    output reg ref_from_supply,
    output reg ref_halve_on,
    output wire conv_done
);

    reg [13:0] ctrl_q;
    reg [1:0] mode_q;
    reg mode_new_q;
    reg ready_q;
    reg [23:0] last_q;
    reg [23:0] shift_q;
    reg [4:0] bit_q;
    reg [5:0] pulse_q;
    reg sck_q;
    reg aw_q;
    reg w_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire sck_rise;
    wire [2:0] sel;
    wire sel_ok;
    wire [1:0] sel_mode;
    reg [31:0] rd_val;
    reg rd_ok;

    // count to mode: returns {valid, mode}; over 32 or under 25 is no change
    function [2:0] mode_of;
        input [5:0] cnt;
        begin
            if (cnt == `ACMC_CNT_R10) begin
                mode_of = {1'b1, `ACMC_MODE_R10};
            end else if (cnt == `ACMC_CNT_SUP) begin
                mode_of = {1'b1, `ACMC_MODE_SUP};
            end else if (cnt == `ACMC_CNT_R40) begin
                mode_of = {1'b1, `ACMC_MODE_R40};
            end else if (cnt >= `ACMC_CNT_USER && cnt <= `ACMC_CNT_MAX) begin
                mode_of = {1'b1, `ACMC_MODE_USER};
            end else begin
                mode_of = {1'b0, `ACMC_MODE_R10};
            end
        end
    endfunction

    assign sel = mode_of(pulse_q);
    assign sel_ok = sel[2];
    assign sel_mode = sel[1:0];
    assign sck_rise = powerdown_shift_clock & ~sck_q;
    assign data_out_oe = 1'b1;

    // conversion period timer
    acmc_rate_div #(
        .CONV_DIV(CONV_DIV),
        .OSR_MIN(OSR_MIN)
    ) u_rate (
        .clk(clk),
        .resetn(resetn),
        .rate_code(conv_rate_code),
        .conv_done(conv_done)
    );

    // analog steering from the active mode and the control register
    always @* begin
        input_buffer_on = ctrl_q[`ACMC_CTRL_BUF];
        ref_halve_on = ~ctrl_q[`ACMC_CTRL_HALVE];
        pos_pin_b = ctrl_q[`ACMC_CTRL_PSEL];
        neg_pin_b = ctrl_q[`ACMC_CTRL_NSEL];
        ref_from_supply = ctrl_q[`ACMC_CTRL_REFSUP];
        case (mode_q)
            `ACMC_MODE_R10: begin
                conv_rate_code = `ACMC_RATE_10;
                amp_gain_code = `ACMC_GAIN_128;
                internal_channel_on = 1'b0;
            end
            `ACMC_MODE_R40: begin
                conv_rate_code = `ACMC_RATE_40;
                amp_gain_code = `ACMC_GAIN_128;
                internal_channel_on = 1'b0;
            end
            `ACMC_MODE_SUP: begin
                conv_rate_code = `ACMC_RATE_40;
                amp_gain_code = `ACMC_GAIN_1;
                internal_channel_on = 1'b1;
                ref_from_supply = 1'b1;
            end
            default: begin
                conv_rate_code = ctrl_q[`ACMC_CTRL_RATE];
                amp_gain_code = ctrl_q[`ACMC_CTRL_GAIN];
                internal_channel_on = ctrl_q[`ACMC_CTRL_CHSEL];
            end
        endcase
    end

    // link clock edge detect
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= powerdown_shift_clock;
        end
    end

    // result shifter and ready flag on the data pin
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= 1'b1;
            shift_q <= 24'h000000;
            last_q <= 24'h000000;
            bit_q <= 5'h00;
            ready_q <= 1'b0;
        end else if (conv_done) begin
            data_out <= 1'b0;
            shift_q <= filter_result;
            last_q <= filter_result;
            bit_q <= 5'h00;
            ready_q <= 1'b1;
        end else if (sck_rise) begin
            ready_q <= 1'b0;
            if (bit_q < `ACMC_DATA_BITS) begin
                data_out <= shift_q[23];
                shift_q <= {shift_q[22:0], 1'b0};
                bit_q <= bit_q + 5'h01;
            end else begin
                data_out <= 1'b1; // idle high until the next result
            end
        end
    end

    // pulse counter; a short count carries into the extended period
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= 6'h00;
        end else if (conv_done) begin
            if (pulse_q != 6'h00 && pulse_q < `ACMC_CNT_R10) begin
                pulse_q <= pulse_q;
            end else begin
                pulse_q <= 6'h00;
            end
        end else if (sck_rise && pulse_q != `ACMC_CNT_SAT) begin
            pulse_q <= pulse_q + 6'h01;
        end
    end

    // next mode taken at the end of the period from the pulse count
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `ACMC_MODE_R10;
            mode_new_q <= 1'b0;
        end else if (conv_done) begin
            if (sel_ok) begin
                mode_q <= sel_mode;
                mode_new_q <= (sel_mode != mode_q);
            end else begin
                mode_new_q <= 1'b0;
            end
        end
    end

    // bus handshakes: address and data taken in either order
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // write channel capture
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (aw_q && w_q) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // register write and write response
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `ACMC_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACMC_RESP_OKAY;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_q && w_q) begin
            s_axi_bvalid <= 1'b1;
            if ({awaddr_q[3:2], 2'h0} == `ACMC_OFS_CTRL) begin
                s_axi_bresp <= `ACMC_RESP_OKAY;
                if (wstrb_q[0]) begin
                    ctrl_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    ctrl_q[13:8] <= wdata_q[13:8];
                end
            end else if ({awaddr_q[3:2], 2'h0} == `ACMC_OFS_STAT ||
                         {awaddr_q[3:2], 2'h0} == `ACMC_OFS_RES) begin
                s_axi_bresp <= `ACMC_RESP_OKAY; // read-only, write ignored
            end else begin
                s_axi_bresp <= `ACMC_RESP_SLVERR;
            end
        end
    end

    // read decode
    always @* begin
        rd_val = 32'h00000000;
        rd_ok = 1'b1;
        case ({s_axi_araddr[3:2], 2'h0})
            `ACMC_OFS_CTRL: begin
                rd_val = {18'h00000, ctrl_q};
            end
            `ACMC_OFS_STAT: begin
                rd_val = {12'h000, pulse_q, 4'h0, mode_new_q, ready_q,
                          amp_gain_code, conv_rate_code, mode_q};
            end
            `ACMC_OFS_RES: begin
                rd_val = {8'h00, last_q};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // read response
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ACMC_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `ACMC_RESP_OKAY : `ACMC_RESP_SLVERR;
        end
    end

endmodule
`default_nettype wire

// file: tb/acmc_mcu_model.sv
// Purpose: controller model clocking results out of the link
// Assumes: link clock sampled by the block on clk
// Notes: clock rests low between bursts, 3 cycles high and 3 low
`timescale 1ns/1ps
`default_nettype none
module acmc_mcu_model (
    input wire logic clk,
    input wire logic data_out,
    input wire logic go,
    input wire logic [5:0] npulses,
    output logic sck,
    output logic busy,
    output logic [23:0] word
);
    int k;
    // burst of pulses after a result is flagged
    initial begin
        sck = 1'b0;
        busy = 1'b0;
        word = 24'h000000;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                while (data_out !== 1'b0) @(posedge clk);
                for (k = 0; k < npulses; k++) begin
                    sck <= 1'b1;
                    repeat (3) @(posedge clk);
                    sck <= 1'b0;
                    repeat (3) @(posedge clk);
                    if (k < 24) word[23 - k] <= data_out;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/acmc_top_monitor.sv
// Purpose: port checker for the conversion mode control block
// Assumes: bound into acmc_top
// Notes: period length skipped across a rate change
`timescale 1ns/1ps
`default_nettype none
module acmc_top_monitor #(
    parameter CONV_DIV = 2048,
    parameter OSR_MIN = 2
) (
    input wire clk,
    input wire resetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire powerdown_shift_clock,
    input wire data_out,
    input wire [2:0] conv_rate_code,
    input wire conv_done
);
    localparam int P0 = CONV_DIV * OSR_MIN;
    logic [31:0] cnt_q;
    logic chg_q;
    logic seen_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // cycles since the last period end, rate change flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 32'h0;
            chg_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            cnt_q <= conv_done ? 32'h1 : cnt_q + 32'h1;
            chg_q <= conv_done ? 1'b0 : (chg_q | $changed(conv_rate_code));
            seen_q <= seen_q | conv_done;
        end
    end
    chk_period_len: assert property (conv_done && seen_q && !chg_q |->
        cnt_q == (P0 << (7 - conv_rate_code))) else $error("period length wrong");
    chk_ready_low: assert property (conv_done |=> !data_out) else $error("ready not flagged");
    chk_data_still: assert property (!powerdown_shift_clock && !$past(powerdown_shift_clock)
        && !$past(powerdown_shift_clock, 2) && !conv_done |=> $stable(data_out)) else $error("data moved");
    chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("no write response");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
endmodule
bind acmc_top acmc_top_monitor #(.CONV_DIV(CONV_DIV), .OSR_MIN(OSR_MIN)) u_acmc_top_monitor (.clk, .resetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .powerdown_shift_clock,
    .data_out, .conv_rate_code, .conv_done);
`default_nettype wire

// file: tb/acmc_top_tb.sv
// Purpose: register and link tests of the conversion mode control block
// Assumes: short divider for fast periods
// Notes: each step checks the mode chosen by the previous pulse count
`timescale 1ns/1ps
`default_nettype none
module acmc_top_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic go = 1'b0;
    logic [5:0] np = 6'h00;
    logic [23:0] filter_result = 24'h000000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, powerdown_shift_clock;
    wire data_out, data_out_oe, conv_done, busy, input_buffer_on, pos_pin_b, neg_pin_b;
    wire internal_channel_on, ref_from_supply, ref_halve_on;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [23:0] word;
    wire [2:0] conv_rate_code, amp_gain_code;
    wire [11:0] st = {conv_rate_code, amp_gain_code, input_buffer_on, pos_pin_b, neg_pin_b,
        internal_channel_on, ref_from_supply, ref_halve_on};
    localparam logic [23:0] VAL [0:6] = '{24'h800000, 24'h7FFFFF, 24'h000000, 24'h123456, 24'h654321,
        24'hA5A5A5, 24'h000001};
    localparam logic [5:0] CNT [0:6] = '{6'h1A, 6'h1B, 6'h1C, 6'h0A, 6'h10, 6'h19, 6'h00};
    localparam logic [11:0] MSK [0:6] = '{12'hFC6, 12'hFC6, 12'hFC6, 12'hFFF, 12'hFFF, 12'hFC6, 12'hFC6};
    localparam logic [11:0] EXP [0:6] = '{12'h1C0, 12'h406, 12'h5C0, 12'h2E8, 12'h2E8, 12'h406, 12'h1C0};
    // status word seen just after each period end: pulses, change flag, ready, gain, rate, mode
    localparam logic [19:0] STS [0:6] = '{20'h001E0, 20'h00309, 20'h003EA, 20'h00367, 20'h28167, 20'h00309,
        20'h003E0};
    int num_errors = 0;
    int checked = 0;
    int i;
    int n;
    // clock of 4 ns
    always #2 clk = ~clk;
    acmc_top #(.CONV_DIV(4), .OSR_MIN(2)) u_acmc_top (.clk, .resetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .powerdown_shift_clock, .data_out, .data_out_oe,
        .filter_result, .conv_rate_code, .amp_gain_code, .input_buffer_on, .pos_pin_b, .neg_pin_b,
        .internal_channel_on, .ref_from_supply, .ref_halve_on, .conv_done);
    acmc_mcu_model u_acmc_mcu_model (.clk, .data_out, .go, .npulses(np), .sck(powerdown_shift_clock),
        .busy, .word);
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one bus transfer; write when wr set, ready raised late on purpose
    task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] ex,
        input logic [1:0] er);
        logic pa, pw, ta, tw, tr;
        logic [31:0] q;
        logic [1:0] r;
        int c;
        pa = 1'b1;
        pw = wr;
        c = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        do begin
            @(negedge clk);
            ta = pa && (wr ? s_axi_awready : s_axi_arready);
            tw = pw && s_axi_wready;
            tr = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
            q = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (ta && wr) s_axi_awvalid <= 1'b0;
            if (ta && !wr) s_axi_arvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            c++;
            if (c == 2 && wr) s_axi_bready <= 1'b1;
            if (c == 2 && !wr) s_axi_rready <= 1'b1;
        end while (!tr);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!wr) check(q, ex);
        check({30'h0, r}, {30'h0, er});
    endtask
    // bounded wait for a period end
    task wait_done;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (conv_done !== 1'b1 && n < 3000);
        check({31'h0, conv_done}, 32'h1);
    endtask
    // reset, register access, then one step per pulse count
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({20'h0, st}, 32'h1D1);
        check({30'h0, data_out, data_out_oe}, 32'h3);
        @(posedge clk);
        xfer(1'b0, 4'h0, 32'h0, 32'h270, 2'h0);
        xfer(1'b0, 4'hC, 32'h0, 32'h0, 2'h2);
        xfer(1'b1, 4'h0, 32'h1531, 32'h0, 2'h0);
        xfer(1'b0, 4'h0, 32'h0, 32'h1531, 2'h0);
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            filter_result <= VAL[i];
            wait_done;
            repeat (2) @(negedge clk);
            check({20'h0, st & MSK[i]}, {20'h0, EXP[i]});
            @(posedge clk);
            xfer(1'b0, 4'h4, 32'h0, {12'h000, STS[i]}, 2'h0);
            xfer(1'b0, 4'h8, 32'h0, {8'h00, VAL[i]}, 2'h0);
            if (CNT[i] != 6'h00) begin
                @(posedge clk);
                go <= 1'b1;
                np <= CNT[i];
                @(posedge clk);
                go <= 1'b0;
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (busy !== 1'b0 && n < 1000);
                if (CNT[i] >= 6'h18) check({8'h0, word}, {8'h0, VAL[i]});
            end
        end
        complete_run;
    end
    // watchdog against a hang
    initial begin
        #200000;
        num_errors++;
        complete_run;
    end
endmodule
`default_nettype wire
